// ==== design/gpio_mux_pkg.sv ====
package gpio_mux_pkg;
	// port widths
	localparam int P0_W = 8;
	localparam int P1_W = 7;
	localparam int P2_W = 8;
	localparam int P3IO_W = 2;
	localparam int P3IN_W = 3;
	localparam int P5IN_W = 2;
	localparam int P5OUT_W = 4;
	localparam int DATA_W = 8;
	// direction bit meaning
	localparam logic DIR_IN = 1'b0;
	localparam logic DIR_OUT = 1'b1;
	// reset values
	localparam logic [7:0] LATCH_RST = 8'h00;
	localparam logic [7:0] DIR_RST = 8'h00;
	localparam logic [7:0] RDATA_RST = 8'h00;
	// alternate function bit positions
	localparam int P1_CLKCTL = 0;
	localparam int P1_BUS1_CLK = 1;
	localparam int P1_BUS2_CLK = 2;
	localparam int P1_BUS1_DAT = 3;
	localparam int P1_BUS2_DAT = 4;
	localparam int P1_TMR2_CLK = 6;
	localparam int P2_SCLK = 0;
	localparam int P2_SOUT = 1;
	localparam int P2_SER_IN = 2;
	localparam int P2_TMR3_CLK = 3;
	localparam int P2_TMR2_CLK = 4;
	localparam int P2_IRQ3 = 5;
	localparam int P2_SUB_IN = 6;
	localparam int P2_SUB_OUT = 7;
	localparam int P3_BUS3_DAT = 0;
	localparam int P3_BUS3_CLK = 1;
	localparam int P3IN_LSB = 5;
	localparam int P5_HSYNC = 0;
	localparam int P5_VSYNC = 1;
	localparam int P5OUT_LSB = 2;
	localparam int P0_AN_LSB = 3;
	// port being accessed
	typedef enum logic [2:0] {SEL_P0, SEL_P1, SEL_P2, SEL_P3, SEL_P5} port_sel_t;
	// one cpu access
	typedef struct packed {
		port_sel_t port;
		logic dir_acc;
		logic wr;
		logic rd;
		logic [DATA_W-1:0] wdata;
	} cpu_req_t;
	// alternate function selects
	typedef struct packed {
		logic i2c_en;
		logic clk_ctl_en;
		logic sio_en;
		logic subclk_en;
		logic osd_en;
	} alt_sel_t;
	// drive requests from the peripherals
	typedef struct packed {
		logic clock_control_out;
		logic bus_ch1_clock;
		logic bus_ch2_clock;
		logic bus_ch1_data;
		logic bus_ch2_data;
		logic bus_ch3_clock;
		logic bus_ch3_data;
		logic sclk_out;
		logic sclk_oe;
		logic sout;
		logic subclock_osc_out;
		logic [P5OUT_W-1:0] osd_colour;
	} periph_drv_t;
	// pin levels handed to the peripherals
	typedef struct packed {
		logic timer_two_ext_clock;
		logic timer_three_ext_clock;
		logic serial_data_in;
		logic sclk_in;
		logic subclock_osc_in;
		logic ext_irq_three;
		logic bus_ch1_clock;
		logic bus_ch2_clock;
		logic bus_ch1_data;
		logic bus_ch2_data;
		logic bus_ch3_clock;
		logic bus_ch3_data;
		logic hsync;
		logic vsync;
		logic [8:1] analog_ch;
	} periph_in_t;
endpackage

// ==== design/port_bank.sv ====
`timescale 1ns/1ns
module port_bank
	import gpio_mux_pkg::*;
#(
	parameter int W = 8,
	parameter bit OPEN_DRAIN = 1'b0
)(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_wr_latch,
	input wire logic i_wr_dir,
	input wire logic [W-1:0] i_wdata,
	input wire logic [W-1:0] i_pin,
	output logic [W-1:0] o_latch,
	output logic [W-1:0] o_dir,
	output logic [W-1:0] o_rval,
	output logic [W-1:0] o_out,
	output logic [W-1:0] o_oe
);
	logic [W-1:0] latch_reg; // port latch
	logic [W-1:0] dir_reg; // direction bits
	// latch takes every write, whatever the direction
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
			latch_reg <= LATCH_RST[W-1:0];
		else if (i_wr_latch)
			latch_reg <= i_wdata;
	end
	// direction bits, all inputs after reset
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
			dir_reg <= DIR_RST[W-1:0];
		else if (i_wr_dir)
			dir_reg <= i_wdata;
	end
	// read: latch for outputs, pin for inputs
	always_comb
	begin
		for (int b = 0; b < W; b++)
			o_rval[b] = (dir_reg[b] == DIR_OUT) ? latch_reg[b] : i_pin[b];
	end
	// ordinary drive; inputs float
	always_comb
	begin
		if (OPEN_DRAIN)
		begin
			o_out = '0;
			o_oe = dir_reg & ~latch_reg;
		end
		else
		begin
			o_out = latch_reg;
			o_oe = dir_reg;
		end
	end
	assign o_latch = latch_reg;
	assign o_dir = dir_reg;
	a_reset_dir_in: assert property (@(posedge i_mclk) !i_rst_n |=> dir_reg == '0)
		else $error("direction not cleared by reset");
	a_dir_follows: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		i_wr_dir |=> o_oe == (OPEN_DRAIN ? ($past(i_wdata) & ~latch_reg) : $past(i_wdata)))
		else $error("drive enable does not follow direction write");
endmodule

// ==== design/port_pin_mux.sv ====
`timescale 1ns/1ns
module port_pin_mux
	import gpio_mux_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire gpio_mux_pkg::cpu_req_t i_req,
	output logic [gpio_mux_pkg::DATA_W-1:0] o_rdata,
	input wire gpio_mux_pkg::alt_sel_t i_alt,
	input wire gpio_mux_pkg::periph_drv_t i_drv,
	output gpio_mux_pkg::periph_in_t o_periph,
	input wire logic [gpio_mux_pkg::P0_W-1:0] i_p0_pin,
	output logic [gpio_mux_pkg::P0_W-1:0] o_p0_out,
	output logic [gpio_mux_pkg::P0_W-1:0] o_p0_oe,
	input wire logic [gpio_mux_pkg::P1_W-1:0] i_p1_pin,
	output logic [gpio_mux_pkg::P1_W-1:0] o_p1_out,
	output logic [gpio_mux_pkg::P1_W-1:0] o_p1_oe,
	input wire logic [gpio_mux_pkg::P2_W-1:0] i_p2_pin,
	output logic [gpio_mux_pkg::P2_W-1:0] o_p2_out,
	output logic [gpio_mux_pkg::P2_W-1:0] o_p2_oe,
	input wire logic [gpio_mux_pkg::P3IO_W-1:0] i_p3_pin,
	output logic [gpio_mux_pkg::P3IO_W-1:0] o_p3_out,
	output logic [gpio_mux_pkg::P3IO_W-1:0] o_p3_oe,
	input wire logic [gpio_mux_pkg::P3IN_W-1:0] i_p3_in,
	input wire logic [gpio_mux_pkg::P5IN_W-1:0] i_p5_in,
	output logic [gpio_mux_pkg::P5OUT_W-1:0] o_p5_out
);
	import gpio_mux_pkg::*;

	// per-port write strobes
	logic wr_lat0, wr_lat1, wr_lat2, wr_lat3, wr_lat5;
	logic wr_dir0, wr_dir1, wr_dir2, wr_dir3;
	// bank results
	logic [P0_W-1:0] lat0, dir0, rv0, out0, oe0;
	logic [P1_W-1:0] lat1, dir1, rv1, out1, oe1;
	logic [P2_W-1:0] lat2, dir2, rv2, out2, oe2;
	logic [P3IO_W-1:0] lat3, dir3, rv3, out3, oe3;
	logic [P5OUT_W-1:0] p5_latch_reg; // output-only latch
	logic [DATA_W-1:0] rdata_reg; // read data
	logic [DATA_W-1:0] rdata_next;

	// decode writes by port and register kind
	always_comb
	begin
		wr_lat0 = i_req.wr && !i_req.dir_acc && i_req.port == SEL_P0;
		wr_lat1 = i_req.wr && !i_req.dir_acc && i_req.port == SEL_P1;
		wr_lat2 = i_req.wr && !i_req.dir_acc && i_req.port == SEL_P2;
		wr_lat3 = i_req.wr && !i_req.dir_acc && i_req.port == SEL_P3;
		wr_lat5 = i_req.wr && !i_req.dir_acc && i_req.port == SEL_P5;
		wr_dir0 = i_req.wr && i_req.dir_acc && i_req.port == SEL_P0;
		wr_dir1 = i_req.wr && i_req.dir_acc && i_req.port == SEL_P1;
		wr_dir2 = i_req.wr && i_req.dir_acc && i_req.port == SEL_P2;
		wr_dir3 = i_req.wr && i_req.dir_acc && i_req.port == SEL_P3;
	end

	// port zero, open-drain ordinary outputs
	port_bank #(.W(P0_W), .OPEN_DRAIN(1'b1)) u_p0 (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_wr_latch(wr_lat0),
		.i_wr_dir(wr_dir0),
		.i_wdata(i_req.wdata[P0_W-1:0]),
		.i_pin(i_p0_pin),
		.o_latch(lat0),
		.o_dir(dir0),
		.o_rval(rv0),
		.o_out(out0),
		.o_oe(oe0)
	);
	// port one, seven bits push-pull
	port_bank #(.W(P1_W), .OPEN_DRAIN(1'b0)) u_p1 (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_wr_latch(wr_lat1),
		.i_wr_dir(wr_dir1),
		.i_wdata(i_req.wdata[P1_W-1:0]),
		.i_pin(i_p1_pin),
		.o_latch(lat1),
		.o_dir(dir1),
		.o_rval(rv1),
		.o_out(out1),
		.o_oe(oe1)
	);
	// port two, eight bits push-pull
	port_bank #(.W(P2_W), .OPEN_DRAIN(1'b0)) u_p2 (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_wr_latch(wr_lat2),
		.i_wr_dir(wr_dir2),
		.i_wdata(i_req.wdata[P2_W-1:0]),
		.i_pin(i_p2_pin),
		.o_latch(lat2),
		.o_dir(dir2),
		.o_rval(rv2),
		.o_out(out2),
		.o_oe(oe2)
	);
	// port three low pair
	port_bank #(.W(P3IO_W), .OPEN_DRAIN(1'b0)) u_p3 (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_wr_latch(wr_lat3),
		.i_wr_dir(wr_dir3),
		.i_wdata(i_req.wdata[P3IO_W-1:0]),
		.i_pin(i_p3_pin),
		.o_latch(lat3),
		.o_dir(dir3),
		.o_rval(rv3),
		.o_out(out3),
		.o_oe(oe3)
	);

	// port five output latch, no direction bits
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
			p5_latch_reg <= LATCH_RST[P5OUT_W-1:0];
		else if (wr_lat5)
			p5_latch_reg <= i_req.wdata[P5OUT_LSB +: P5OUT_W];
	end

	// read value; unused bits read zero
	always_comb
	begin
		rdata_next = '0;
		case (i_req.port)
			SEL_P0:
				rdata_next[P0_W-1:0] = i_req.dir_acc ? dir0 : rv0;
			SEL_P1:
				rdata_next[P1_W-1:0] = i_req.dir_acc ? dir1 : rv1;
			SEL_P2:
				rdata_next[P2_W-1:0] = i_req.dir_acc ? dir2 : rv2;
			SEL_P3:
			begin
				rdata_next[P3IO_W-1:0] = i_req.dir_acc ? dir3 : rv3;
				if (!i_req.dir_acc)
					rdata_next[P3IN_LSB +: P3IN_W] = i_p3_in;
			end
			SEL_P5:
			begin
				if (!i_req.dir_acc)
				begin
					rdata_next[P5IN_W-1:0] = i_p5_in;
					rdata_next[P5OUT_LSB +: P5OUT_W] = p5_latch_reg;
				end
			end
			default:
				rdata_next = '0;
		endcase
	end

	// read data registered on each read strobe
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
			rdata_reg <= RDATA_RST;
		else if (i_req.rd)
			rdata_reg <= rdata_next;
	end
	assign o_rdata = rdata_reg;

	// port zero has no drive overrides
	always_comb
	begin
		o_p0_out = out0;
		o_p0_oe = oe0;
	end

	// port one with clock control and bus lines
	always_comb
	begin
		o_p1_out = out1;
		o_p1_oe = oe1;
		if (i_alt.clk_ctl_en)
		begin
			o_p1_out[P1_CLKCTL] = i_drv.clock_control_out;
			o_p1_oe[P1_CLKCTL] = 1'b1;
		end
		if (i_alt.i2c_en)
		begin
			// open-drain: pull low only
			o_p1_out[P1_BUS1_CLK] = 1'b0;
			o_p1_out[P1_BUS2_CLK] = 1'b0;
			o_p1_out[P1_BUS1_DAT] = 1'b0;
			o_p1_out[P1_BUS2_DAT] = 1'b0;
			o_p1_oe[P1_BUS1_CLK] = !i_drv.bus_ch1_clock;
			o_p1_oe[P1_BUS2_CLK] = !i_drv.bus_ch2_clock;
			o_p1_oe[P1_BUS1_DAT] = !i_drv.bus_ch1_data;
			o_p1_oe[P1_BUS2_DAT] = !i_drv.bus_ch2_data;
		end
	end

	// port two with serial and sub-clock pins
	always_comb
	begin
		o_p2_out = out2;
		o_p2_oe = oe2;
		if (i_alt.sio_en)
		begin
			// open-drain clock and data out; data in floats
			o_p2_out[P2_SCLK] = 1'b0;
			o_p2_oe[P2_SCLK] = i_drv.sclk_oe && !i_drv.sclk_out;
			o_p2_out[P2_SOUT] = 1'b0;
			o_p2_oe[P2_SOUT] = !i_drv.sout;
			o_p2_out[P2_SER_IN] = 1'b0;
			o_p2_oe[P2_SER_IN] = 1'b0;
		end
		if (i_alt.subclk_en)
		begin
			o_p2_out[P2_SUB_IN] = 1'b0;
			o_p2_oe[P2_SUB_IN] = 1'b0;
			o_p2_out[P2_SUB_OUT] = i_drv.subclock_osc_out;
			o_p2_oe[P2_SUB_OUT] = 1'b1;
		end
	end

	// port three pair doubles as bus channel three
	always_comb
	begin
		o_p3_out = out3;
		o_p3_oe = oe3;
		if (i_alt.i2c_en)
		begin
			o_p3_out = '0;
			o_p3_oe[P3_BUS3_DAT] = !i_drv.bus_ch3_data;
			o_p3_oe[P3_BUS3_CLK] = !i_drv.bus_ch3_clock;
		end
	end

	// port five outputs, always driven push-pull
	always_comb
	begin
		o_p5_out = i_alt.osd_en ? i_drv.osd_colour : p5_latch_reg;
	end

	// pin levels handed to the peripherals
	always_comb
	begin
		o_periph.timer_two_ext_clock = i_p2_pin[P2_TMR2_CLK] | i_p1_pin[P1_TMR2_CLK];
		o_periph.timer_three_ext_clock = i_p2_pin[P2_TMR3_CLK];
		o_periph.serial_data_in = i_p2_pin[P2_SER_IN];
		o_periph.sclk_in = i_p2_pin[P2_SCLK];
		o_periph.subclock_osc_in = i_p2_pin[P2_SUB_IN];
		o_periph.ext_irq_three = i_p2_pin[P2_IRQ3];
		o_periph.bus_ch1_clock = i_p1_pin[P1_BUS1_CLK];
		o_periph.bus_ch2_clock = i_p1_pin[P1_BUS2_CLK];
		o_periph.bus_ch1_data = i_p1_pin[P1_BUS1_DAT];
		o_periph.bus_ch2_data = i_p1_pin[P1_BUS2_DAT];
		o_periph.bus_ch3_clock = i_p3_pin[P3_BUS3_CLK];
		o_periph.bus_ch3_data = i_p3_pin[P3_BUS3_DAT];
		o_periph.hsync = i_p5_in[P5_HSYNC];
		o_periph.vsync = i_p5_in[P5_VSYNC];
		// analog channels one to eight
		o_periph.analog_ch[4:1] = i_p0_pin[P0_AN_LSB +: 4];
		o_periph.analog_ch[7:5] = i_p2_pin[P2_SER_IN:P2_SCLK];
		o_periph.analog_ch[8] = i_p1_pin[P1_TMR2_CLK];
	end

	// checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	// write port two latch, one idle cycle, then make bit zero an output
	sequence s_p2_out_bit0;
		i_req.wr && !i_req.dir_acc && i_req.port == SEL_P2 && !i_alt.sio_en
			##1 !i_req.wr
			##1 i_req.wr && i_req.dir_acc && i_req.port == SEL_P2 && i_req.wdata[0];
	endsequence
	sequence s_p2_read_data;
		i_req.rd && !i_req.dir_acc && i_req.port == SEL_P2;
	endsequence

	a_latch_drives_pin: assert property (
		s_p2_out_bit0 ##1 !i_req.wr && !i_alt.sio_en
			|-> o_p2_oe[0] && o_p2_out[0] == $past(i_req.wdata[0], 3))
		else $error("port two latch not driven after output select");
	a_out_reads_latch: assert property (
		s_p2_read_data ##0 dir2[0] |=> o_rdata[0] == $past(lat2[0]))
		else $error("output pin read did not return latch");
	a_in_reads_pin: assert property (
		s_p2_read_data ##0 !dir2[3] |=> o_rdata[3] == $past(i_p2_pin[3]))
		else $error("input pin read did not return pin level");
	a_in_floats: assert property (
		!dir1[5] && !i_alt.i2c_en |-> !o_p1_oe[5])
		else $error("input pin is driven");
	a_p3_high_in: assert property (
		i_req.rd && !i_req.dir_acc && i_req.port == SEL_P3
			|=> o_rdata[7:5] == $past(i_p3_in) && o_rdata[4:2] == 3'h0)
		else $error("port three upper read wrong");
	a_p5_out_src: assert property (
		$rose(i_alt.osd_en) |-> o_p5_out == i_drv.osd_colour)
		else $error("colour outputs not selected");
	a_bus_od_low: assert property (
		i_alt.i2c_en && !i_drv.bus_ch1_data |-> o_p1_oe[3] && !o_p1_out[3])
		else $error("bus data one not pulled low");
	a_bus3_release: assert property (
		i_alt.i2c_en && i_drv.bus_ch3_clock |-> !o_p3_oe[1])
		else $error("bus clock three not released");
	a_clkctl_drive: assert property (
		i_alt.clk_ctl_en |-> o_p1_oe[0] && o_p1_out[0] == i_drv.clock_control_out)
		else $error("clock control not driven");
	a_sout_od: assert property (
		i_alt.sio_en && i_drv.sout |-> !o_p2_oe[1] && !o_p2_oe[2])
		else $error("serial pins driven when released");
	a_subclk_out: assert property (
		i_alt.subclk_en |-> o_p2_oe[7] && !o_p2_oe[6])
		else $error("sub-clock pins wrong direction");
	a_reset_float: assert property (
		$rose(i_rst_n) |-> dir0 == '0 && dir1 == '0 && dir2 == '0 && dir3 == '0
			&& o_p0_oe == '0)
		else $error("port driven right after reset");

	// pin routing to the peripherals and the output-only port
	a_timer3_route: assert property (
		o_periph.timer_three_ext_clock == i_p2_pin[P2_TMR3_CLK])
		else $error("timer three clock not routed");
	a_irq3_route: assert property (
		o_periph.ext_irq_three == i_p2_pin[P2_IRQ3])
		else $error("interrupt three not routed");
	a_sync_route: assert property (
		o_periph.hsync == i_p5_in[P5_HSYNC] && o_periph.vsync == i_p5_in[P5_VSYNC])
		else $error("sync inputs not routed");
	a_analog_route: assert property (
		o_periph.analog_ch[8] == i_p1_pin[P1_TMR2_CLK])
		else $error("analog channel eight not routed");
	a_p5_latch_out: assert property (
		!i_alt.osd_en |-> o_p5_out == p5_latch_reg)
		else $error("port five latch not on outputs");
endmodule

// ==== verif/board_model.sv ====
`timescale 1ns/1ns
// board side of the port pins: drives where the chip lets go, else pull-up
module board_model #(
	parameter int W = 25
)(
	input wire logic [W-1:0] i_out,
	input wire logic [W-1:0] i_oe,
	input wire logic [W-1:0] i_ext,
	input wire logic [W-1:0] i_ext_en,
	output logic [W-1:0] o_pin
);
	// resolve each wire; two drivers that disagree give an unknown level
	always_comb
	begin
		for (int i = 0; i < W; i++)
		begin
			if (i_oe[i] && i_ext_en[i])
				o_pin[i] = (i_out[i] === i_ext[i]) ? i_out[i] : 1'bx;
			else if (i_oe[i])
				o_pin[i] = i_out[i];
			else if (i_ext_en[i])
				o_pin[i] = i_ext[i];
			else
				o_pin[i] = 1'b1; // released line floats up
		end
	end
endmodule

// ==== verif/tb.sv ====
`timescale 1ns/1ns
module tb;
	import gpio_mux_pkg::*;
	logic i_mclk;
	logic i_rst_n;
	cpu_req_t i_req;
	alt_sel_t i_alt;
	periph_drv_t i_drv;
	periph_in_t o_periph;
	logic [7:0] o_rdata;
	logic [2:0] i_p3_in;
	logic [1:0] i_p5_in;
	logic [3:0] o_p5_out;
	// ports 0..3 packed: p0 7:0, p1 14:8, p2 22:15, p3 24:23
	wire logic [24:0] pin, out, oe;
	logic [24:0] ext, ext_en;
	int bad_count;
	int checks;
	logic [31:0] lfsr;
	logic [7:0] msk [4] = '{8'hff, 8'h7f, 8'hff, 8'h03};
	logic [7:0] lat [4];
	logic [7:0] dir [4];

	port_pin_mux port_pin_mux_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_req(i_req),
		.o_rdata(o_rdata), .i_alt(i_alt), .i_drv(i_drv), .o_periph(o_periph),
		.i_p0_pin(pin[7:0]), .o_p0_out(out[7:0]), .o_p0_oe(oe[7:0]),
		.i_p1_pin(pin[14:8]), .o_p1_out(out[14:8]), .o_p1_oe(oe[14:8]),
		.i_p2_pin(pin[22:15]), .o_p2_out(out[22:15]), .o_p2_oe(oe[22:15]),
		.i_p3_pin(pin[24:23]), .o_p3_out(out[24:23]), .o_p3_oe(oe[24:23]),
		.i_p3_in(i_p3_in), .i_p5_in(i_p5_in), .o_p5_out(o_p5_out));
	board_model board_model_inst (.i_out(out), .i_oe(oe), .i_ext(ext), .i_ext_en(ext_en),
		.o_pin(pin));

	// clock, 4 ns period
	initial
	begin
		i_mclk = 1'b0;
		forever #2 i_mclk = ~i_mclk;
	end

	// pseudo-random source, fixed start
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], ^(lfsr & 32'h8020_0003)};
		return lfsr;
	endfunction

	// one port's slice of the packed pin vectors
	function automatic logic [7:0] fld(input logic [24:0] v, input int p);
		case (p)
			0: fld = v[7:0];
			1: fld = {1'b0, v[14:8]};
			2: fld = v[22:15];
			default: fld = {6'h00, v[24:23]};
		endcase
	endfunction

	// one access, write when w is high, else read; read data valid on return
	task automatic acc(input port_sel_t p, input logic d, input logic w, input logic [7:0] v);
		@(negedge i_mclk);
		i_req = '{p, d, w, ~w, v};
		@(negedge i_mclk);
		i_req.wr = 1'b0;
		i_req.rd = 1'b0;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// reset for two cycles, then ports 0..3 must be inputs again and the port five latch clear
	task automatic rst_chk();
		i_rst_n = 1'b0;
		repeat (2) @(negedge i_mclk);
		i_rst_n = 1'b1;
		chk(o_rdata, 8'h00);
		chk({4'h0, o_p5_out}, 8'h00);
		for (int k = 0; k < 4; k++)
		begin
			lat[k] = 8'h00;
			dir[k] = 8'h00;
			chk(fld(oe, k), 8'h00);
			acc(port_sel_t'(k), 1'b1, 1'b0, 8'h00);
			chk(o_rdata, 8'h00);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// watchdog against a hang
	initial
	begin
		#200000;
		bad_count++;
		end_of_test();
	end

	initial
	begin
		int p;
		logic [7:0] l;
		logic [7:0] d;
		logic [7:0] x;
		logic [31:0] r;
		lfsr = 32'h0000_0686;
		bad_count = 0;
		checks = 0;
		i_req = '0;
		i_alt = '0;
		i_drv = '0;
		ext = '0;
		ext_en = '0;
		i_p3_in = '0;
		i_p5_in = '0;
		// all pins of ports 0..3 inputs after reset
		rst_chk();
		// latch, direction, read-back on the four bidirectional ports
		for (int n = 0; n < 48; n++)
		begin
			p = n % 4;
			r = rnd();
			l = (n < 4) ? 8'h5a : r[7:0];
			d = (n < 4) ? 8'hff : ((n < 8) ? 8'h00 : r[15:8]);
			ext_en = '0;
			acc(port_sel_t'(p), 1'b0, 1'b1, l);
			acc(port_sel_t'(p), 1'b1, 1'b1, d);
			lat[p] = l & msk[p];
			dir[p] = d & msk[p];
			r = rnd();
			ext = r[24:0];
			ext_en = ~{dir[3][1:0], dir[2], dir[1][6:0], dir[0]};
			i_p3_in = r[27:25];
			acc(port_sel_t'(p), 1'b0, 1'b0, 8'h00);
			x = ((dir[p] & lat[p]) | (~dir[p] & fld(ext, p))) & msk[p];
			if (p == 3)
				chk(o_rdata, {i_p3_in, 5'h00} | x);
			else
				chk(o_rdata & msk[p], x);
			acc(port_sel_t'(p), 1'b1, 1'b0, 8'h00);
			chk(o_rdata & msk[p], dir[p]);
			if (p == 0)
			begin
				chk(fld(oe, 0), dir[0] & ~lat[0]);
				chk(fld(out, 0), 8'h00);
			end
			else
			begin
				chk(fld(oe, p), dir[p]);
				chk(fld(out, p) & dir[p], lat[p] & dir[p]);
			end
		end
		// reset again in mid-run with ports set up
		rst_chk();
		// port five: sync inputs, output latch or display colour
		for (int n = 0; n < 8; n++)
		begin
			r = rnd();
			i_alt.osd_en = r[8];
			i_drv.osd_colour = r[12:9];
			i_p5_in = r[14:13];
			acc(SEL_P5, 1'b0, 1'b1, r[7:0]);
			acc(SEL_P5, 1'b1, 1'b1, r[15:8]);
			acc(SEL_P5, 1'b0, 1'b0, 8'h00);
			chk(o_rdata, {2'b00, r[5:2], i_p5_in});
			acc(SEL_P5, 1'b1, 1'b0, 8'h00);
			chk(o_rdata, 8'h00);
			chk({4'h0, o_p5_out}, {4'h0, r[8] ? r[12:9] : r[5:2]});
			chk({6'h00, o_periph.vsync, o_periph.hsync}, {6'h00, i_p5_in});
		end
		// alternates on top of ports 1..3 set as outputs, port 0 set as inputs
		ext_en = '0;
		acc(SEL_P0, 1'b1, 1'b1, 8'h00);
		for (int k = 1; k < 4; k++)
			acc(port_sel_t'(k), 1'b1, 1'b1, 8'hff);
		for (int n = 0; n < 16; n++)
		begin
			r = rnd();
			ext = r[24:0];
			ext_en = 25'h022_00ff;
			i_drv = r[14:0];
			i_alt = 5'h1f;
			l = r[31:24];
			acc(SEL_P2, 1'b0, 1'b1, l);
			x = fld(oe, 1);
			chk({3'b000, x[4:0]}, {3'b000, ~i_drv.bus_ch2_data, ~i_drv.bus_ch1_data,
				~i_drv.bus_ch2_clock, ~i_drv.bus_ch1_clock, 1'b1});
			chk({3'b000, out[12:9] & oe[12:9], out[8]},
				{7'h00, i_drv.clock_control_out});
			chk({4'h0, oe[24:23], out[24:23] & oe[24:23]},
				{4'h0, ~i_drv.bus_ch3_clock, ~i_drv.bus_ch3_data, 2'b00});
			chk(oe[22:15], {5'b10111, 1'b0, ~i_drv.sout,
				i_drv.sclk_oe & ~i_drv.sclk_out});
			chk({1'b0, out[22], out[20:18], out[16:15] & oe[16:15], 1'b0},
				{1'b0, i_drv.subclock_osc_out, l[5:3], 3'b000});
			chk({o_periph.timer_three_ext_clock, o_periph.timer_two_ext_clock,
				o_periph.ext_irq_three, o_periph.serial_data_in, o_periph.sclk_in,
				o_periph.subclock_osc_in, 2'b00},
				{pin[18], pin[19] | pin[14], pin[20], pin[17], pin[15], pin[21],
				2'b00});
			chk(o_periph.analog_ch, {pin[14], pin[17:15], pin[6:3]});
			chk({2'b00, o_periph.bus_ch1_clock, o_periph.bus_ch2_clock,
				o_periph.bus_ch1_data, o_periph.bus_ch2_data, o_periph.bus_ch3_clock,
				o_periph.bus_ch3_data},
				{2'b00, pin[9], pin[10], pin[11], pin[12], pin[24], pin[23]});
		end
		end_of_test();
	end
endmodule
